// ===== daq_seq.v
// acquisition sequencer: list, triggers, pacing, waveform, bus master
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`include "daq_regs.vh"
module daq_seq
#(
  parameter PW = 27,
  parameter DW = 16
)
(
  // clock and reset
  input  wire          clk_i,
  input  wire          rst_i,
  // wishbone slave
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [7:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  // converter front end
  output reg  [4:0]    adc_chan_o,
  output reg  [1:0]    adc_gain_o,
  output reg           adc_bipolar_o,
  output reg           adc_conv_o,
  input  wire          adc_done_i,
  input  wire [DW-1:0] adc_data_i,
  // trigger and clock pins
  input  wire          dig_trig_i,
  input  wire          ao_trig_i,
  input  wire          ext_clk_i,
  input  wire          ana_thr_i,
  output reg           conv_clk_out_o,
  output reg           trig_out_o,
  // output converters
  output reg  [DW-1:0] dac0_o,
  output reg  [DW-1:0] dac1_o,
  output reg           dac_load_o,
  output reg           filt0_en_o,
  output reg           filt1_en_o,
  // host memory master
  output reg  [31:0]   dma_adr_o,
  output reg  [DW-1:0] dma_dat_o,
  output reg           dma_req_o,
  input  wire          dma_ack_i
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg  [3:0] pin_s1_q;
  reg  [3:0] pin_s2_q;
  reg  [3:0] pin_s3_q;
  wire [3:0] pin_rise;

  always @(posedge clk_i)
  begin
    pin_s1_q <= {ana_thr_i, ext_clk_i, ao_trig_i, dig_trig_i};
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
  end
  assign pin_rise = pin_s2_q & ~pin_s3_q;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg  [31:0]   ctrl_q;
  reg  [31:0]   count_q;
  reg  [PW-1:0] rate_q;
  reg  [PW-1:0] gap_q;
  reg  [8:0]    retrig_q;
  reg  [10:0]   listlen_q;
  reg  [12:0]   wavelen_q;
  reg  [PW-1:0] orate_q;
  reg  [31:0]   dbase_q;
  reg  [31:0]   dsize_q;
  reg  [DW-1:0] athr_q;
  reg  [DW-1:0] last_q;
  reg           done_q;
  reg           ovr_q;
  reg           trigd_q;
  reg  [9:0]    lwr_q;
  reg  [11:0]   wwr_q;
  reg  [11:0]   list_mem [0:`DAQ_LIST_DEPTH-1];
  reg  [31:0]   wave_mem [0:`DAQ_WAVE_DEPTH-1];
  reg  [31:0]   wdat;
  reg  [4:0]    st_q;
  reg           ai_en_q;
  wire          busy = !st_q[0];
  integer       b;
  localparam [PW-1:0] MAX_PER = `DAQ_MAX_PERIOD;
  localparam [PW-1:0] MIN_PER = `DAQ_MIN_PERIOD;

  wire          wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire          wb_wr  = wb_req && wb_we_i;
  wire [1:0]    mode   = ctrl_q[`DAQ_C_MODE_HI:`DAQ_C_MODE_LO];
  wire          ai_en  = ctrl_q[`DAQ_C_AI_EN];
  wire          sw_trig = wb_wr && (wb_adr_i == `DAQ_CTRL_OFS) &&
                          wb_sel_i[0] && wb_dat_i[`DAQ_C_SWTRIG];
  wire          single_go = wb_wr && (wb_adr_i == `DAQ_SINGLE_OFS);
  reg           set_done;
  reg           set_ovr;
  reg           set_trigd;

  always @*
  begin
    for (b = 0; b < 4; b = b + 1)
    begin
      wdat[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : ctrl_q[b*8 +: 8];
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o  <= 1'b0;
      ctrl_q    <= 32'h0000_0000;
      count_q   <= 32'h0000_0000;
      rate_q    <= MAX_PER;
      gap_q     <= MAX_PER;
      retrig_q  <= 9'h001;
      listlen_q <= 11'h001;
      wavelen_q <= 13'h0002;
      orate_q   <= MIN_PER;
      dbase_q   <= 32'h0000_0000;
      dsize_q   <= 32'h0000_0000;
      athr_q    <= 16'h8000;
      lwr_q     <= 10'h000;
      wwr_q     <= 12'h000;
      done_q    <= 1'b0;
      ovr_q     <= 1'b0;
      trigd_q   <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      // hardware set wins over write-one clear
      done_q  <= set_done  | (done_q & ~(wb_wr && wb_adr_i ==
                 `DAQ_STAT_OFS && wb_dat_i[`DAQ_S_DONE]));
      ovr_q   <= set_ovr   | (ovr_q & ~(wb_wr && wb_adr_i ==
                 `DAQ_STAT_OFS && wb_dat_i[`DAQ_S_OVR]));
      trigd_q <= set_trigd | (trigd_q & ~(wb_wr && wb_adr_i ==
                 `DAQ_STAT_OFS && wb_dat_i[`DAQ_S_TRIGD]));
      if (wb_wr)
      begin
        case (wb_adr_i)
          `DAQ_CTRL_OFS:    ctrl_q <= wdat & ~(32'h1 << `DAQ_C_SWTRIG);
          `DAQ_COUNT_OFS:   count_q <= wb_dat_i;
          `DAQ_RATE_OFS:    rate_q <= (wb_dat_i[PW-1:0] < `DAQ_MIN_PERIOD)
                            ? MIN_PER : wb_dat_i[PW-1:0];
          `DAQ_SCANGAP_OFS: gap_q <= wb_dat_i[PW-1:0];
          `DAQ_RETRIG_OFS:  retrig_q <= (wb_dat_i[8:0] > 9'h100) ? 9'h100 :
                            wb_dat_i[8:0];
          `DAQ_LISTLEN_OFS:
          begin
            listlen_q <= wb_dat_i[10:0];
            lwr_q     <= 10'h000;
          end
          `DAQ_LISTWR_OFS:
          begin
            list_mem[lwr_q] <= wb_dat_i[11:0];
            lwr_q <= lwr_q + 10'h001;
          end
          `DAQ_WAVELEN_OFS:
          begin
            wavelen_q <= (wb_dat_i[12:0] < `DAQ_WAVE_MIN) ? 13'h0002 :
                         (wb_dat_i[12:0] > `DAQ_WAVE_DEPTH) ? 13'h1000 :
                         wb_dat_i[12:0];
            wwr_q     <= 12'h000;
          end
          `DAQ_WAVEWR_OFS:
          begin
            wave_mem[wwr_q] <= wb_dat_i;
            wwr_q <= wwr_q + 12'h001;
          end
          `DAQ_ORATE_OFS:   orate_q <= (wb_dat_i[PW-1:0] < `DAQ_MIN_PERIOD)
                            ? MIN_PER : wb_dat_i[PW-1:0];
          `DAQ_DMABASE_OFS: dbase_q <= wb_dat_i;
          `DAQ_DMASIZE_OFS: dsize_q <= wb_dat_i;
          `DAQ_ATHR_OFS:    athr_q <= wb_dat_i[DW-1:0];
          default:          ;
        endcase
      end
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      case (wb_adr_i)
        `DAQ_CTRL_OFS:    wb_dat_o <= ctrl_q;
        `DAQ_STAT_OFS:    wb_dat_o <= {28'h0, trigd_q, busy, ovr_q, done_q};
        `DAQ_COUNT_OFS:   wb_dat_o <= count_q;
        `DAQ_RATE_OFS:    wb_dat_o <= {{(32-PW){1'b0}}, rate_q};
        `DAQ_SCANGAP_OFS: wb_dat_o <= {{(32-PW){1'b0}}, gap_q};
        `DAQ_RETRIG_OFS:  wb_dat_o <= {23'h0, retrig_q};
        `DAQ_LISTLEN_OFS: wb_dat_o <= {21'h0, listlen_q};
        `DAQ_WAVELEN_OFS: wb_dat_o <= {19'h0, wavelen_q};
        `DAQ_ORATE_OFS:   wb_dat_o <= {{(32-PW){1'b0}}, orate_q};
        `DAQ_DMABASE_OFS: wb_dat_o <= dbase_q;
        `DAQ_DMASIZE_OFS: wb_dat_o <= dsize_q;
        `DAQ_ATHR_OFS:    wb_dat_o <= {16'h0, athr_q};
        `DAQ_SAMPLE_OFS:  wb_dat_o <= {16'h0, last_q};
        default:          wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // trigger selection
  // ------------------------------------------------------------
  reg  thr_above_q;
  wire thr_pin  = ctrl_q[`DAQ_C_ACH_DED] && pin_rise[3];
  wire thr_chan = !ctrl_q[`DAQ_C_ACH_DED] && adc_done_i &&
                  (adc_chan_o == ctrl_q[`DAQ_C_ACH_HI:`DAQ_C_ACH_LO]) &&
                  (adc_data_i >= athr_q) && !thr_above_q;
  wire ana_trig = thr_pin || thr_chan;
  wire dig_src  = ctrl_q[`DAQ_C_SYNC] ? pin_rise[1] : pin_rise[0];
  wire hw_trig  = ctrl_q[`DAQ_C_ATRIG] ? ana_trig : dig_src;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      thr_above_q <= 1'b0;
    end
    else if (adc_done_i &&
             adc_chan_o == ctrl_q[`DAQ_C_ACH_HI:`DAQ_C_ACH_LO])
    begin
      thr_above_q <= (adc_data_i >= athr_q);
    end
  end

  // ------------------------------------------------------------
  // input sequencer
  // ------------------------------------------------------------
  localparam S_IDLE = 5'h01;
  localparam S_ARM  = 5'h02;
  localparam S_RUN  = 5'h04;
  localparam S_CONV = 5'h08;
  localparam S_GAP  = 5'h10;

  reg  [9:0]    idx_q;
  reg  [31:0]   taken_q;
  reg  [8:0]    pass_q;
  reg  [17:0]   trig_n_q;
  reg  [PW-1:0] gap_cnt_q;
  reg           storing_q;
  reg           single_q;
  reg           last_pass_q;
  wire          pace_tick;
  wire          list_end = ({1'b0, idx_q} == listlen_q - 11'h001);
  wire          count_end = !ctrl_q[`DAQ_C_CONT] &&
                            (taken_q + 32'h1 >= count_q);

  daq_pacer #(.W(PW)) u_ai_pace (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .run_i      ((st_q[2] || st_q[3]) && !single_q),
    .ext_sel_i  (ctrl_q[`DAQ_C_EXTCLK]),
    .ext_edge_i (pin_rise[2]),
    .period_i   (rate_q),
    .tick_o     (pace_tick)
  );

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q        <= S_IDLE;
      idx_q       <= 10'h000;
      taken_q     <= 32'h0000_0000;
      pass_q      <= 9'h000;
      trig_n_q    <= 18'h00000;
      gap_cnt_q   <= {PW{1'b0}};
      storing_q   <= 1'b0;
      single_q    <= 1'b0;
      last_pass_q <= 1'b0;
      ai_en_q     <= 1'b0;
      adc_conv_o  <= 1'b0;
      adc_chan_o  <= 5'h00;
      adc_gain_o  <= 2'h0;
      adc_bipolar_o <= 1'b0;
      set_done    <= 1'b0;
      set_trigd   <= 1'b0;
      trig_out_o  <= 1'b0;
      conv_clk_out_o <= 1'b0;
    end
    else
    begin
      adc_conv_o     <= 1'b0;
      set_done       <= 1'b0;
      set_trigd      <= 1'b0;
      trig_out_o     <= hw_trig || sw_trig;
      conv_clk_out_o <= pace_tick;
      adc_bipolar_o  <= ctrl_q[`DAQ_C_BIPOLAR];
      ai_en_q        <= ai_en;
      if (hw_trig && mode == `DAQ_MODE_ABOUT && (st_q[2] || st_q[3]))
      begin
        set_trigd <= 1'b1;
      end
      case (st_q)
        S_IDLE:
        begin
          idx_q <= 10'h000;
          pass_q <= 9'h000;
          trig_n_q <= 18'h00000;
          if (single_go)
          begin
            adc_chan_o <= wb_dat_i[4:0];
            adc_gain_o <= wb_dat_i[9:8];
            adc_conv_o <= 1'b1;
            single_q   <= 1'b1;
            storing_q  <= 1'b1;
            st_q       <= S_CONV;
          end
          // start on enable edge only: a finished run stays stopped
          else if (ai_en && !ai_en_q)
          begin
            taken_q   <= 32'h0000_0000;
            single_q  <= 1'b0;
            storing_q <= (mode != `DAQ_MODE_POST);
            st_q      <= (mode == `DAQ_MODE_POST ||
                          ctrl_q[`DAQ_C_RETRIG]) ? S_ARM : S_RUN;
          end
        end
        S_ARM:
        begin
          if (!ai_en)
          begin
            st_q <= S_IDLE;
          end
          else if (hw_trig || sw_trig)
          begin
            storing_q <= 1'b1;
            set_trigd <= 1'b1;
            st_q      <= S_RUN;
          end
        end
        S_RUN:
        begin
          if (!ai_en)
          begin
            st_q <= S_IDLE;
          end
          else if (hw_trig && mode == `DAQ_MODE_PRE)
          begin
            set_trigd <= 1'b1;
            st_q      <= S_IDLE;
          end
          else if (pace_tick || (ctrl_q[`DAQ_C_SCAN] && idx_q != 10'h000))
          begin
            adc_chan_o <= list_mem[idx_q][4:0];
            adc_gain_o <= list_mem[idx_q][9:8];
            adc_conv_o <= 1'b1;
            last_pass_q <= list_end;
            st_q <= S_CONV;
          end
        end
        S_CONV:
        begin
          if (hw_trig && storing_q && mode == `DAQ_MODE_PRE)
          begin
            set_trigd <= 1'b1;
            st_q      <= S_IDLE;
          end
          else if (adc_done_i)
          begin
            taken_q  <= taken_q + 32'h1;
            trig_n_q <= trig_n_q + 18'h00001;
            idx_q    <= list_end ? 10'h000 : idx_q + 10'h001;
            if (single_q)
            begin
              set_done <= 1'b1;
              st_q     <= S_IDLE;
            end
            else if (count_end)
            begin
              set_done <= 1'b1;
              st_q     <= S_IDLE;
            end
            else if (ctrl_q[`DAQ_C_RETRIG] && (trig_n_q ==
                     `DAQ_TRIG_SAMPLES - 1 || (list_end &&
                     pass_q + 9'h001 >= retrig_q)))
            begin
              pass_q   <= 9'h000;
              trig_n_q <= 18'h00000;
              idx_q    <= 10'h000;
              st_q     <= S_ARM;
            end
            else if (ctrl_q[`DAQ_C_SCAN] && list_end)
            begin
              gap_cnt_q <= gap_q;
              st_q      <= S_GAP;
            end
            else
            begin
              pass_q <= list_end ? pass_q + 9'h001 : pass_q;
              st_q   <= S_RUN;
            end
          end
        end
        S_GAP:
        begin
          gap_cnt_q <= gap_cnt_q - {{(PW-1){1'b0}}, 1'b1};
          if (!ai_en || gap_cnt_q == {PW{1'b0}})
          begin
            st_q <= ai_en ? S_RUN : S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // scan bursts ignore the pacer while mid-list: next entry at once
  // ------------------------------------------------------------
  // host memory master
  // ------------------------------------------------------------
  reg [31:0] dofs_q;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dma_req_o <= 1'b0;
      dma_adr_o <= 32'h0000_0000;
      dma_dat_o <= {DW{1'b0}};
      dofs_q    <= 32'h0000_0000;
      last_q    <= {DW{1'b0}};
      set_ovr   <= 1'b0;
    end
    else
    begin
      set_ovr <= 1'b0;
      if (dma_req_o && dma_ack_i)
      begin
        dma_req_o <= 1'b0;
      end
      if (st_q[3] && adc_done_i && storing_q)
      begin
        last_q <= adc_data_i;
        if (dma_req_o && !dma_ack_i)
        begin
          set_ovr <= 1'b1;
        end
        else
        begin
          dma_req_o <= 1'b1;
          dma_dat_o <= adc_data_i;
          dma_adr_o <= dbase_q + dofs_q;
          // ring in the host block so about-trigger keeps history
          dofs_q <= (dofs_q + 32'h2 >= dsize_q) ? 32'h0 :
                    dofs_q + 32'h2;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // waveform output, independent of the input path
  // ------------------------------------------------------------
  reg  [11:0] widx_q;
  wire        ao_tick;
  wire        ao_run = ctrl_q[`DAQ_C_AO_EN];

  daq_pacer #(.W(PW)) u_ao_pace (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .run_i      (ao_run),
    .ext_sel_i  (ctrl_q[`DAQ_C_AO_EXT]),
    .ext_edge_i (pin_rise[1]),
    .period_i   (orate_q),
    .tick_o     (ao_tick)
  );

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      widx_q     <= 12'h000;
      dac0_o     <= {DW{1'b0}};
      dac1_o     <= {DW{1'b0}};
      dac_load_o <= 1'b0;
      filt0_en_o <= 1'b0;
      filt1_en_o <= 1'b0;
    end
    else
    begin
      filt0_en_o <= ctrl_q[`DAQ_C_FILT0];
      filt1_en_o <= ctrl_q[`DAQ_C_FILT1];
      dac_load_o <= ao_tick;
      if (!ao_run)
      begin
        widx_q <= 12'h000;
      end
      else if (ao_tick)
      begin
        dac0_o <= wave_mem[widx_q][15:0];
        dac1_o <= wave_mem[widx_q][31:16];
        widx_q <= ({1'b0, widx_q} == wavelen_q - 13'h0001) ? 12'h000 :
                  widx_q + 12'h001;
      end
    end
  end
endmodule

// ===== daq_regs.vh
// register offsets, fields and timing counts of the acquisition sequencer
`ifndef DAQ_REGS_VH
`define DAQ_REGS_VH
`define DAQ_CTRL_OFS     8'h00
`define DAQ_STAT_OFS     8'h04
`define DAQ_COUNT_OFS    8'h08
`define DAQ_RATE_OFS     8'h0C
`define DAQ_SCANGAP_OFS  8'h10
`define DAQ_RETRIG_OFS   8'h14
`define DAQ_LISTLEN_OFS  8'h18
`define DAQ_LISTWR_OFS   8'h1C
`define DAQ_WAVELEN_OFS  8'h20
`define DAQ_WAVEWR_OFS   8'h24
`define DAQ_ORATE_OFS    8'h28
`define DAQ_DMABASE_OFS  8'h2C
`define DAQ_DMASIZE_OFS  8'h30
`define DAQ_ATHR_OFS     8'h34
`define DAQ_SINGLE_OFS   8'h38
`define DAQ_SAMPLE_OFS   8'h3C
// control register fields
`define DAQ_C_AI_EN      0
`define DAQ_C_MODE_LO    1
`define DAQ_C_MODE_HI    2
`define DAQ_C_SCAN       3
`define DAQ_C_RETRIG     4
`define DAQ_C_EXTCLK     5
`define DAQ_C_SWTRIG     6
`define DAQ_C_ATRIG      7
`define DAQ_C_SYNC       8
`define DAQ_C_BIPOLAR    9
`define DAQ_C_AO_EN      10
`define DAQ_C_AO_EXT     11
`define DAQ_C_FILT0      12
`define DAQ_C_FILT1      13
`define DAQ_C_ACH_DED    14
`define DAQ_C_CONT       15
`define DAQ_C_ACH_LO     16
`define DAQ_C_ACH_HI     20
// trigger modes
`define DAQ_MODE_POST    2'h0
`define DAQ_MODE_PRE     2'h1
`define DAQ_MODE_ABOUT   2'h2
// status fields
`define DAQ_S_DONE       0
`define DAQ_S_OVR        1
`define DAQ_S_BUSY       2
`define DAQ_S_TRIGD      3
// limits
`define DAQ_LIST_DEPTH   1024
`define DAQ_WAVE_DEPTH   4096
`define DAQ_WAVE_MIN     2
`define DAQ_RETRIG_MAX   256
`define DAQ_TRIG_SAMPLES 262144
`define DAQ_MAX_RATE_HZ  500000
`define DAQ_CLK_HZ       100000000
// fastest pacing period in clocks, rounded up
`define DAQ_MIN_PERIOD ((`DAQ_CLK_HZ + `DAQ_MAX_RATE_HZ - 1) / `DAQ_MAX_RATE_HZ)
// internal pacing period loaded at reset: one per second
`define DAQ_MAX_PERIOD   (`DAQ_CLK_HZ)
`endif

// ===== daq_pacer.v
// programmable period tick generator with internal/external source
`timescale 1ns/1ps
module daq_pacer
#(
  parameter W = 27
)
(
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // control
  input  wire         run_i,
  input  wire         ext_sel_i,
  input  wire         ext_edge_i,
  input  wire [W-1:0] period_i,
  // tick
  output wire         tick_o
);
  reg  [W-1:0] cnt_q;
  wire         int_tick;

  assign int_tick = run_i && (cnt_q == {W{1'b0}});
  assign tick_o   = run_i && (ext_sel_i ? ext_edge_i : int_tick);

  always @(posedge clk_i)
  begin
    if (rst_i || !run_i || int_tick)
    begin
      cnt_q <= period_i - {{(W-1){1'b0}}, 1'b1};
    end
    else
    begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ===== daq_seq_checker.sv
// port assertions for the acquisition sequencer
`timescale 1ns/1ps
module daq_seq_checker
#(
  parameter DW = 16
)
(
  // clock and reset
  input wire logic          clk_i,
  input wire logic          rst_i,
  // register bus
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_ack_o,
  // pins and output converters
  input wire logic          conv_clk_out_o,
  input wire logic          trig_out_o,
  input wire logic [DW-1:0] dac0_o,
  input wire logic [DW-1:0] dac1_o,
  input wire logic          dac_load_o,
  // host memory master
  input wire logic [31:0]   dma_adr_o,
  input wire logic [DW-1:0] dma_dat_o,
  input wire logic          dma_req_o,
  input wire logic          dma_ack_i
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_answer_a:
  assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  ack_pulse_a:
  assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_idle_a:
  assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  dma_hold_a:
  assert property (dma_req_o && !dma_ack_i |=>
    dma_req_o && $stable(dma_adr_o) && $stable(dma_dat_o))
    else $error("master request not held");
  dma_drop_a:
  assert property (dma_req_o && dma_ack_i |=> !dma_req_o)
    else $error("master request not dropped");
  dac_sync_a:
  assert property ($changed(dac0_o) || $changed(dac1_o) |-> dac_load_o)
    else $error("output moved without load");
  load_pulse_a:
  assert property (dac_load_o |=> !dac_load_o)
    else $error("load too long");
  clk_pulse_a:
  assert property (conv_clk_out_o |=> !conv_clk_out_o)
    else $error("clock out too long");
  trig_pulse_a:
  assert property (trig_out_o |=> !trig_out_o)
    else $error("trigger out too long");
endmodule

bind daq_seq daq_seq_checker #(.DW(DW)) daq_seq_checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .conv_clk_out_o(conv_clk_out_o), .trig_out_o(trig_out_o),
  .dac0_o(dac0_o), .dac1_o(dac1_o), .dac_load_o(dac_load_o),
  .dma_adr_o(dma_adr_o), .dma_dat_o(dma_dat_o),
  .dma_req_o(dma_req_o), .dma_ack_i(dma_ack_i)
);

// ===== daq_host_mem.sv
// host memory model answering the bus master writes
`timescale 1ns/1ps
module daq_host_mem
#(
  parameter LAT = 3
)
(
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // master side
  input  wire        req_i,
  input  wire [31:0] adr_i,
  output reg         ack_o,
  // observation
  output reg  [15:0] cnt_o,
  output reg  [31:0] adr_o
);
  reg [3:0] wait_q;
  // slow answer, so a held request is exercised
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o  <= 1'b0;
      wait_q <= 4'h0;
      cnt_o  <= 16'h0;
      adr_o  <= 32'h0;
    end
    else if (ack_o)
    begin
      ack_o  <= 1'b0;
      wait_q <= 4'h0;
    end
    else if (req_i && wait_q == LAT)
    begin
      ack_o <= 1'b1;
      cnt_o <= cnt_o + 16'h1;
      adr_o <= adr_i;
    end
    else if (req_i)
      wait_q <= wait_q + 4'h1;
  end
endmodule

// ===== daq_acquisition_sequencer_tb.sv
// self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
`include "daq_regs.vh"
module daq_acquisition_sequencer_tb;
  // ----
  // signals
  // ----
  reg          clk_i = 1'b0, rst_i = 1'b1;
  reg          wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  reg  [7:0]   wb_adr_i = 8'h0;
  reg  [3:0]   wb_sel_i = 4'h0;
  reg  [31:0]  wb_dat_i = 32'h0, rd_q;
  reg          adc_done_i = 1'b0, dig_trig_i = 1'b0;
  reg  [15:0]  adc_data_i = 16'h0;
  wire [31:0]  wb_dat_o, dma_adr_o, mem_adr;
  wire [15:0]  dac0_o, dac1_o, dma_dat_o, mem_cnt;
  wire [4:0]   adc_chan_o;
  wire [1:0]   adc_gain_o;
  wire         wb_ack_o, adc_bipolar_o, adc_conv_o, conv_clk_out_o;
  wire         trig_out_o, dac_load_o, filt0_en_o, filt1_en_o;
  wire         dma_req_o, dma_ack_i;
  reg  [7:0]   ch_q [0:63];
  reg  [31:0]  ld_q [0:15];
  reg  [2:0]   dly_q = 3'h0;
  integer      mismatches = 0, check_count = 0, nconv = 0, nld = 0;
  integer      ntrig = 0, cyc = 0, lastc = 0, gap = 0, b, c;

  daq_seq daq_seq_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .adc_chan_o(adc_chan_o),
    .adc_gain_o(adc_gain_o), .adc_bipolar_o(adc_bipolar_o),
    .adc_conv_o(adc_conv_o), .adc_done_i(adc_done_i),
    .adc_data_i(adc_data_i), .dig_trig_i(dig_trig_i),
    .ao_trig_i(1'b0), .ext_clk_i(cyc[5]), .ana_thr_i(1'b0),
    .conv_clk_out_o(conv_clk_out_o), .trig_out_o(trig_out_o),
    .dac0_o(dac0_o), .dac1_o(dac1_o), .dac_load_o(dac_load_o),
    .filt0_en_o(filt0_en_o), .filt1_en_o(filt1_en_o),
    .dma_adr_o(dma_adr_o), .dma_dat_o(dma_dat_o),
    .dma_req_o(dma_req_o), .dma_ack_i(dma_ack_i)
  );
  daq_host_mem #(.LAT(3)) daq_host_mem_i (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(dma_req_o),
    .adr_i(dma_adr_o), .ack_o(dma_ack_i), .cnt_o(mem_cnt),
    .adr_o(mem_adr)
  );
  initial forever #5 clk_i = ~clk_i;
  // ----
  // converter model and recorders
  // ----
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    adc_done_i <= 1'b0;
    adc_data_i <= ~adc_data_i;
    if (adc_conv_o)
    begin
      ch_q[nconv] <= {adc_bipolar_o, adc_gain_o, adc_chan_o};
      nconv <= nconv + 1;
      dly_q <= 3'h3;
    end
    else if (dly_q != 3'h0)
      dly_q <= dly_q - 3'h1;
    if (dly_q == 3'h1)
    begin
      adc_done_i <= 1'b1;
      adc_data_i <= {11'h540, adc_chan_o};
    end
    if (dac_load_o)
    begin
      ld_q[nld] <= {dac1_o, dac0_o};
      nld <= nld + 1;
    end
    if (conv_clk_out_o)
    begin
      gap <= cyc - lastc;
      lastc <= cyc;
    end
    if (trig_out_o)
      ntrig <= ntrig + 1;
  end
  // ----
  // shared tasks
  // ----
  task chk(input [31:0] got, input [31:0] exp, input string m);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: %s %h/%h", $time, m, got, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      @(posedge clk_i);
      // no limit of its own: the watchdog ends a hang
      while (wb_ack_o !== 1'b1)
        @(posedge clk_i);
      rd_q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task upto(input integer sel, input integer k);
    begin
      while ((sel == 0 ? nconv : nld) < k)
        @(posedge clk_i);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_regs_single;
    begin
      bus(1'b0, `DAQ_RATE_OFS, 32'h0);
      chk(rd_q, 32'h05F5E100, "rate reset");
      bus(1'b1, `DAQ_RATE_OFS, 32'hC8);
      bus(1'b1, 8'h40, 32'hFFFF);
      bus(1'b0, 8'h40, 32'h0);
      chk(rd_q, 32'h0, "unmapped");
      bus(1'b1, `DAQ_CTRL_OFS, 32'h200);
      b = nconv;
      bus(1'b1, `DAQ_SINGLE_OFS, 32'h305);
      upto(0, b + 1);
      repeat (8) @(posedge clk_i);
      chk(32'(ch_q[b]), 32'hE5, "chan gain range");
      bus(1'b0, `DAQ_SAMPLE_OFS, 32'h0);
      chk(rd_q, 32'hA805, "sample");
      $display("test regs and single done");
    end
  endtask
  task t_list;
    begin
      bus(1'b1, `DAQ_CTRL_OFS, 32'h0);
      bus(1'b1, `DAQ_LISTLEN_OFS, 32'h3);
      bus(1'b1, `DAQ_LISTWR_OFS, 32'h3);
      bus(1'b1, `DAQ_LISTWR_OFS, 32'h107);
      bus(1'b1, `DAQ_LISTWR_OFS, 32'h31F);
      bus(1'b1, `DAQ_COUNT_OFS, 32'h6);
      bus(1'b1, `DAQ_DMABASE_OFS, 32'h1000);
      bus(1'b1, `DAQ_DMASIZE_OFS, 32'h100);
      bus(1'b1, `DAQ_STAT_OFS, 32'hF);
      bus(1'b1, `DAQ_CTRL_OFS, 32'h1);
      c = mem_cnt;
      repeat (500) @(posedge clk_i);
      chk(mem_cnt - c, 32'h0, "stored early");
      b = nconv;
      bus(1'b1, `DAQ_CTRL_OFS, 32'h41);
      upto(0, b + 6);
      repeat (600) @(posedge clk_i);
      chk(nconv - b, 32'h6, "conversions");
      chk(mem_cnt - c, 32'h6, "stored");
      for (int i = 0; i < 6; i++)
        chk(32'(ch_q[b + i]), i % 3 == 0 ? 32'h3 :
          (i % 3 == 1 ? 32'h27 : 32'h7F), "list");
      chk(gap, 32'hC8, "pacing");
      chk(dma_dat_o, 32'hA81F, "data");
      chk(32'(mem_adr - 32'h1000 < 32'h100), 32'h1, "addr");
      bus(1'b0, `DAQ_STAT_OFS, 32'h0);
      chk(rd_q & 32'h3, 32'h1, "status");
      bus(1'b1, `DAQ_CTRL_OFS, 32'h0);
      $display("test list done");
    end
  endtask
  task t_pre;
    begin
      b = nconv;
      bus(1'b1, `DAQ_CTRL_OFS, 32'h8023);
      upto(0, b + 2);
      c = ntrig;
      dig_trig_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      dig_trig_i <= 1'b0;
      repeat (50) @(posedge clk_i);
      b = nconv;
      repeat (600) @(posedge clk_i);
      chk(nconv - b, 32'h0, "run after trigger");
      chk(ntrig - c, 32'h1, "trigger out");
      chk(gap, 32'h40, "ext pacing");
      bus(1'b1, `DAQ_CTRL_OFS, 32'h0);
      $display("test pre-trigger done");
    end
  endtask
  task t_wave;
    begin
      bus(1'b1, `DAQ_WAVELEN_OFS, 32'h2);
      bus(1'b1, `DAQ_WAVEWR_OFS, 32'h22221111);
      bus(1'b1, `DAQ_WAVEWR_OFS, 32'h44443333);
      bus(1'b1, `DAQ_ORATE_OFS, 32'hC8);
      b = nld;
      bus(1'b1, `DAQ_CTRL_OFS, 32'h2400);
      upto(1, b + 3);
      chk(ld_q[b], 32'h22221111, "first");
      chk(ld_q[b + 1], 32'h44443333, "second");
      chk(ld_q[b + 2], 32'h22221111, "wrap");
      chk({filt1_en_o, filt0_en_o}, 32'h2, "filters");
      $display("test waveform done");
    end
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs_single;
    t_list;
    t_pre;
    t_wave;
    summarize;
  end
  // whole run needs about 4000 cycles
  initial
  begin
    repeat (30000) @(posedge clk_i);
    mismatches = mismatches + 1;
    summarize;
  end
endmodule
